// [rrre_exec.sv]
// execution unit for software reset, returns and rotate-left
// Notes on behaviour
// RL1 - the software reset opcode raises a full device reset request from the instruction stream.
// RL2 - the software reset opcode clears the reset-instruction flag and touches no status flag.
// RL3 - the interrupt return pops the stack and loads the popped top entry into the pc.
// RL4 - the interrupt return sets the global interrupt enable, bit 7 of interrupt control.
// RL5 - the interrupt return is one word, takes two cycles and leaves status flags alone.
// RL6 - the subroutine return pops the stack into the pc in two cycles with flags untouched.
// RL7 - the literal return loads its 8-bit immediate into the accumulator with no flag change.
// RL8 - the literal return also reloads the pc from the stack top and takes two cycles.
// RL9 - rotate-left shifts the addressed file register one bit left through carry.
// RL10 - rotate-left writes the accumulator when the destination bit is 0, the file when 1.
// RL11 - rotate-left changes only carry and completes in a single cycle.
// RL12 - old carry enters result bit 0, old bit 7 becomes carry, source untouched for accumulator.
// RL13 - two-cycle returns flush the fetched next instruction and run a no-op second cycle.
//
// The implementer's own choices: the address map and register access over APB.
`timescale 1ns/1ps
module rrre_exec
   import rrre_pkg::*;
(
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [RRRE_ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // instruction and operands
   input wire logic instr_valid,
   input wire logic [13:0] instr_word,
   input wire logic [RRRE_PC_W-1:0] stack_top_entry,
   input wire logic [7:0] file_rdata,
   // core side results
   output logic pc_load_q,
   output logic [RRRE_PC_W-1:0] pc_target_q,
   output logic stack_pop_q,
   output logic fetch_flush_q,
   output logic file_we_q,
   output logic [6:0] file_addr_q,
   output logic [7:0] file_wdata_q,
   output logic [7:0] w_q,
   output logic carry_q,
   output logic global_irq_enable_q,
   output logic reset_req_q,
   output logic reset_instruction_flag_clr_q,
   output logic busy_q
);
   rrre_state_t state_q;
   rrre_state_t state_d;
   logic enable_q;
   logic [31:0] rd_mux;
   logic [7:0] w_d;
   logic carry_d;
   logic irq_en_d;

   // opcode field compare, shared by the literal return and rotate decode
   function automatic logic hi_match(input logic [13:0] word, input logic [5:0] code);
      return word[RRRE_HI_MSB:RRRE_HI_LSB] == code;
   endfunction

   // decode, all combinational
   wire logic take = instr_valid && enable_q && (state_q == RRRE_ST_EXEC);
   wire logic is_reset = take && (instr_word == RRRE_OP_RESET);
   wire logic is_return = take && (instr_word == RRRE_OP_RETURN);
   wire logic is_irq_ret = take && (instr_word == RRRE_OP_IRQ_RETURN);
   wire logic is_lit_ret = take && hi_match(instr_word, RRRE_OP_LIT_RETURN_HI);
   wire logic is_rotate = take && hi_match(instr_word, RRRE_OP_ROTATE_HI);
   wire logic is_ret = is_return || is_irq_ret || is_lit_ret;
   wire logic rot_to_file = instr_word[RRRE_DEST_BIT];
   wire logic [6:0] file_sel = instr_word[RRRE_FILE_MSB:0];
   wire logic [7:0] lit_val = instr_word[RRRE_LIT_MSB:0];
   // nine-bit rotation: old carry in at bit 0, old bit 7 out to carry
   wire logic [7:0] rot_res = {file_rdata[RRRE_LIT_MSB-1:0], carry_q}; // [RL9] [RL12]
   wire logic rot_c = file_rdata[RRRE_LIT_MSB]; // [RL12]

   // apb decode
   wire logic setup = psel && !penable;
   wire logic acc = psel && penable;
   wire logic hit_intctl = paddr == RRRE_INTCTL_OFS;
   wire logic hit_core = paddr == RRRE_CORE_OFS;
   wire logic hit_status = paddr == RRRE_STATUS_OFS;
   wire logic hit_enable = paddr == RRRE_ENABLE_OFS;
   wire logic hit_any = hit_intctl || hit_core || hit_status || hit_enable;
   wire logic wr = acc && pwrite;
   wire logic wr_intctl = wr && hit_intctl;
   wire logic wr_core = wr && hit_core;
   wire logic wr_enable = wr && hit_enable;

   // read data, one address chain
   always_comb begin
      rd_mux = 32'h0000_0000;
      if (hit_intctl) begin
         rd_mux[RRRE_IRQ_EN_BIT] = global_irq_enable_q;
      end else if (hit_core) begin
         rd_mux[RRRE_LIT_MSB:0] = w_q;
         rd_mux[RRRE_CARRY_BIT] = carry_q;
      end else if (hit_status) begin
         rd_mux[RRRE_PC_W-1:0] = pc_target_q;
         rd_mux[RRRE_STATE_LSB +: $bits(rrre_state_t)] = state_q;
      end else if (hit_enable) begin
         rd_mux[RRRE_ENABLE_BIT] = enable_q;
      end
   end

   // next state
   always_comb begin
      state_d = state_q;
      case (state_q)
         RRRE_ST_EXEC: begin
            if (is_reset) begin
               state_d = RRRE_ST_RESET; // [RL1]
            end else if (is_ret) begin
               state_d = RRRE_ST_FLUSH; // [RL5] [RL6] [RL8]
            end
         end
         // second cycle is a no-op while the new target is fetched
         RRRE_ST_FLUSH: begin
            state_d = RRRE_ST_EXEC; // [RL13]
         end
         // held until the sequencer resets us
         RRRE_ST_RESET: begin
            state_d = RRRE_ST_RESET;
         end
         default: begin
            state_d = RRRE_ST_EXEC;
         end
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_q <= RRRE_ST_EXEC;
      end else begin
         state_q <= state_d;
      end
   end

   // accumulator; instructions win over a same-cycle apb write
   always_comb begin
      w_d = w_q;
      if (is_lit_ret) begin
         w_d = lit_val; // [RL7]
      end else if (is_rotate) begin
         if (!rot_to_file) begin
            w_d = rot_res; // [RL10]
         end
      end else if (wr_core) begin
         w_d = pwdata[RRRE_LIT_MSB:0];
      end
   end

   // carry; the literal return keeps it, so software loses that cycle too
   always_comb begin
      carry_d = carry_q;
      if (is_lit_ret) begin
         carry_d = carry_q; // [RL7]
      end else if (is_rotate) begin
         carry_d = rot_c; // [RL11]
      end else if (wr_core) begin
         carry_d = pwdata[RRRE_CARRY_BIT];
      end
   end

   // set by the interrupt return beats a software clear
   always_comb begin
      irq_en_d = global_irq_enable_q;
      if (is_irq_ret) begin
         irq_en_d = 1'b1; // [RL4]
      end else if (wr_intctl) begin
         irq_en_d = pwdata[RRRE_IRQ_EN_BIT];
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pc_load_q <= 1'b0;
      end else begin
         pc_load_q <= is_ret; // [RL3] [RL6] [RL8]
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         stack_pop_q <= 1'b0;
      end else begin
         stack_pop_q <= is_ret; // [RL3] [RL6] [RL8]
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         fetch_flush_q <= 1'b0;
      end else begin
         fetch_flush_q <= is_ret; // [RL13]
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pc_target_q <= '0;
      end else if (is_ret) begin
         pc_target_q <= stack_top_entry; // [RL3] [RL6] [RL8]
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         file_we_q <= 1'b0;
      end else begin
         file_we_q <= is_rotate && rot_to_file; // [RL10] [RL12]
      end
   end

   // address and data hold after the strobe, even for an accumulator result
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         file_addr_q <= '0;
      end else if (is_rotate) begin
         file_addr_q <= file_sel; // [RL9]
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         file_wdata_q <= '0;
      end else if (is_rotate) begin
         file_wdata_q <= rot_res; // [RL9]
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         w_q <= RRRE_W_RST;
      end else begin
         w_q <= w_d;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         carry_q <= RRRE_C_RST;
      end else begin
         carry_q <= carry_d;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         global_irq_enable_q <= RRRE_IRQ_EN_RST;
      end else begin
         global_irq_enable_q <= irq_en_d;
      end
   end

   // sticky: only a device reset may release the core
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         reset_req_q <= 1'b0;
      end else begin
         reset_req_q <= reset_req_q || is_reset; // [RL1]
      end
   end

   // cause flag lives in the sequencer, so only its clear is pulsed here
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         reset_instruction_flag_clr_q <= 1'b0;
      end else begin
         reset_instruction_flag_clr_q <= is_reset; // [RL2]
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         busy_q <= 1'b0;
      end else begin
         busy_q <= state_d != RRRE_ST_EXEC;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         enable_q <= RRRE_ENABLE_RST;
      end else if (wr_enable) begin
         enable_q <= pwdata[RRRE_ENABLE_BIT];
      end
   end

   // apb answers in the access cycle with no wait state
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready <= 1'b0;
      end else begin
         pready <= setup;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pslverr <= 1'b0;
      end else begin
         pslverr <= setup && !hit_any;
      end
   end

   // read data taken in setup, so it stands through the access cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= '0;
      end else begin
         prdata <= (setup && !pwrite) ? rd_mux : 32'h0000_0000;
      end
   end
endmodule

// [rrre_pkg.sv]
// constants for the return, reset and rotate execution block
package rrre_pkg;
   // opcode encodings of the 14-bit instruction word
   localparam logic [13:0] RRRE_OP_RESET = 14'h0001;
   localparam logic [13:0] RRRE_OP_RETURN = 14'h0008;
   localparam logic [13:0] RRRE_OP_IRQ_RETURN = 14'h0009;
   localparam logic [5:0] RRRE_OP_LIT_RETURN_HI = 6'h34;
   localparam logic [5:0] RRRE_OP_ROTATE_HI = 6'h0d;
   // instruction and register field positions
   localparam int RRRE_HI_MSB = 13;
   localparam int RRRE_HI_LSB = 8;
   localparam int RRRE_DEST_BIT = 7;
   localparam int RRRE_FILE_MSB = 6;
   localparam int RRRE_LIT_MSB = 7;
   localparam int RRRE_IRQ_EN_BIT = 7;
   localparam int RRRE_CARRY_BIT = 8;
   localparam int RRRE_ENABLE_BIT = 0;
   localparam int RRRE_STATE_LSB = 16;
   // widths
   localparam int RRRE_PC_W = 15;
   localparam int RRRE_ADDR_W = 12;
   // register byte offsets
   localparam logic [11:0] RRRE_INTCTL_OFS = 12'h000;
   localparam logic [11:0] RRRE_CORE_OFS = 12'h004;
   localparam logic [11:0] RRRE_STATUS_OFS = 12'h008;
   localparam logic [11:0] RRRE_ENABLE_OFS = 12'h00c;
   // reset values
   localparam logic RRRE_IRQ_EN_RST = 1'b0;
   localparam logic [7:0] RRRE_W_RST = 8'h00;
   localparam logic RRRE_C_RST = 1'b0;
   localparam logic RRRE_ENABLE_RST = 1'b1;
   // execution states
   typedef enum logic [2:0] {
      RRRE_ST_EXEC = 3'b001,
      RRRE_ST_FLUSH = 3'b010,
      RRRE_ST_RESET = 3'b100
   } rrre_state_t;
endpackage

// [rrre_chk.sv]
// concurrent checks on the return, reset and rotate execution block
`timescale 1ns/1ps
module rrre_chk
   import rrre_pkg::*;
(
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // instruction side
   input wire logic instr_valid,
   input wire logic [13:0] instr_word,
   input wire logic [RRRE_PC_W-1:0] stack_top_entry,
   input wire logic [7:0] file_rdata,
   // results
   input wire logic pc_load_q,
   input wire logic [RRRE_PC_W-1:0] pc_target_q,
   input wire logic stack_pop_q,
   input wire logic fetch_flush_q,
   input wire logic file_we_q,
   input wire logic [7:0] file_wdata_q,
   input wire logic [7:0] w_q,
   input wire logic carry_q,
   input wire logic global_irq_enable_q,
   input wire logic reset_req_q,
   input wire logic reset_instruction_flag_clr_q,
   input wire logic busy_q
);
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   // enable register is not visible here, so the bench issues instructions only while it holds its reset value
   wire tk = instr_valid && !busy_q;
   wire lw = tk && instr_word[13:8] == RRRE_OP_LIT_RETURN_HI;
   wire rt = lw || tk && (instr_word == RRRE_OP_RETURN || instr_word == RRRE_OP_IRQ_RETURN);
   wire rl = tk && instr_word[13:8] == RRRE_OP_ROTATE_HI;
   wire [7:0] lit = instr_word[7:0];
   wire [8:0] rot = {file_rdata, carry_q};
   a_ret_load: assert property (rt |=> pc_load_q && stack_pop_q
      && pc_target_q == $past(stack_top_entry)) else $error("return load wrong");
   a_ret_flush: assert property (rt |=> fetch_flush_q && busy_q ##1 !busy_q && !pc_load_q)
      else $error("return flush wrong");
   a_irq_en_set: assert property (tk && instr_word == RRRE_OP_IRQ_RETURN |=> global_irq_enable_q)
      else $error("interrupt enable not set");
   a_lit_load: assert property (lw |=> w_q == $past(lit) && $stable(carry_q))
      else $error("literal load wrong");
   a_rot_w: assert property (rl && !instr_word[7] |=> {carry_q, w_q} == $past(rot)
      && !file_we_q) else $error("rotate to accumulator wrong");
   a_rot_file: assert property (rl && instr_word[7] |=> file_we_q && $stable(w_q)
      && {carry_q, file_wdata_q} == $past(rot)) else $error("rotate to file wrong");
   a_rot_single: assert property (rl |=> !busy_q && !pc_load_q)
      else $error("rotate not single cycle");
   a_sw_reset: assert property (tk && instr_word == RRRE_OP_RESET |=>
      reset_req_q && reset_instruction_flag_clr_q ##1 reset_req_q && busy_q
      && !reset_instruction_flag_clr_q) else $error("software reset wrong");
endmodule

// [return_reset_rotate_exec_tb.sv]
// self-checking bench for the return, reset and rotate execution block
`timescale 1ns/1ps
`define CHK(a, e) begin n_tests++; if ((a) !== (e)) begin n_fail++; \
   $display("unexpected at %0t: got %h want %h", $time, a, e); end end
module return_reset_rotate_exec_tb import rrre_pkg::*; ;
   typedef struct {logic [13:0] wd; logic [7:0] fr; logic [14:0] st;
      logic [7:0] w; logic c; logic [14:0] x;} rrre_row_t;
   logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic instr_valid = 1'b0, pready, pslverr, er, pc_load_q, stack_pop_q, fetch_flush_q;
   logic file_we_q, carry_q, global_irq_enable_q, reset_req_q, reset_instruction_flag_clr_q;
   logic busy_q, is_rot;
   logic [3:0] pulses;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, prdata, rd;
   logic [13:0] instr_word = 14'h0000;
   logic [14:0] stack_top_entry = 15'h0000, pc_target_q;
   logic [7:0] file_rdata = 8'h00, file_wdata_q, w_q;
   logic [6:0] file_addr_q;
   int n_fail = 0, n_tests = 0, cyc = 0;
   // x is the pc target for returns, the held file write data for rotates
   rrre_row_t rows [8] = '{'{14'h0d05, 8'he6, 15'h0, 8'hcc, 1'b1, 15'h0cc},
      '{14'h0d05, 8'h01, 15'h0, 8'h03, 1'b0, 15'h003},
      '{14'h0dff, 8'hff, 15'h0, 8'h03, 1'b1, 15'h0fe},
      '{14'h0d85, 8'h80, 15'h0, 8'h03, 1'b1, 15'h001},
      '{14'h34ff, 8'h00, 15'h7fff, 8'hff, 1'b1, 15'h7fff},
      '{14'h0008, 8'h00, 15'h0123, 8'hff, 1'b1, 15'h0123},
      '{14'h0009, 8'h00, 15'h4000, 8'hff, 1'b1, 15'h4000},
      '{14'h3400, 8'h00, 15'h0001, 8'h00, 1'b1, 15'h0001}};
   rrre_exec i_dut (.*);
   initial forever #25 pclk = ~pclk;
   task automatic end_of_test();
      $display("tests %0d failures %0d", n_tests, n_fail);
      if (n_fail == 0 && n_tests > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   // hangs are cut short here
   always @(posedge pclk) begin
      cyc <= cyc + 1;
      if (cyc == 2000) begin
         n_fail++;
         end_of_test();
      end
   end
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic issue(input logic [13:0] a, input logic [13:0] b, input logic [7:0] f);
      @(posedge pclk);
      instr_valid <= 1'b1;
      instr_word <= a;
      @(posedge pclk);
      instr_word <= b;
      file_rdata <= f;
      @(posedge pclk);
      instr_valid <= 1'b0;
      #1;
   endtask
   initial begin
      repeat (16) @(posedge pclk);
      presetn <= 1'b1;
      #1;
      `CHK({reset_req_q, global_irq_enable_q, carry_q, w_q}, 11'h000)
      foreach (rows[i]) begin
         is_rot = rows[i].wd[13:8] == RRRE_OP_ROTATE_HI;
         pulses = is_rot ? {rows[i].wd[7], 3'b000} : 4'b0111;
         @(posedge pclk);
         instr_valid <= 1'b1;
         instr_word <= rows[i].wd;
         file_rdata <= rows[i].fr;
         stack_top_entry <= rows[i].st;
         @(posedge pclk);
         instr_valid <= 1'b0;
         #1;
         `CHK(w_q, rows[i].w)
         `CHK(carry_q, rows[i].c)
         `CHK(is_rot ? {7'h00, file_wdata_q} : pc_target_q, rows[i].x)
         `CHK({file_we_q, pc_load_q, stack_pop_q, fetch_flush_q}, pulses)
         if (is_rot) `CHK(file_addr_q, rows[i].wd[6:0])
         if (busy_q === 1'b1) @(posedge pclk);
      end
      `CHK(global_irq_enable_q, 1'b1)
      // rotate in the flushed slot after a return must not run
      issue(RRRE_OP_RETURN, 14'h0d00, 8'h00);
      `CHK({carry_q, w_q}, 9'h100)
      apb(1'b1, RRRE_CORE_OFS, 32'h15a);
      apb(1'b0, RRRE_CORE_OFS, 32'h0);
      `CHK(rd, 32'h15a)
      apb(1'b0, RRRE_INTCTL_OFS, 32'h0);
      `CHK(rd, 32'h80)
      apb(1'b0, RRRE_STATUS_OFS, 32'h0);
      `CHK(rd, 32'h0001_0001)
      apb(1'b1, RRRE_ENABLE_OFS, 32'h0);
      apb(1'b0, RRRE_ENABLE_OFS, 32'h0);
      `CHK(rd, 32'h0)
      apb(1'b1, RRRE_ENABLE_OFS, 32'h1);
      apb(1'b0, RRRE_ENABLE_OFS, 32'h0);
      `CHK(rd, 32'h1)
      apb(1'b0, 12'h010, 32'h0);
      `CHK({er, rd}, 33'h100000000)
      // software reset holds off later words until a device reset
      issue(RRRE_OP_RESET, 14'h0d00, 8'h00);
      `CHK({reset_req_q, busy_q, carry_q, w_q}, 11'h75a)
      @(posedge pclk);
      presetn <= 1'b0;
      @(posedge pclk);
      presetn <= 1'b1;
      #1;
      `CHK({reset_req_q, busy_q, global_irq_enable_q, w_q}, 11'h000)
      end_of_test();
   end
endmodule
bind rrre_exec rrre_chk i_chk (.*);
